// *** core/cmem_jump_consts.vh ***
// constants for the compressed load/store and jump expander
// assumes: included by bare name from core design files only
`ifndef CMEM_JUMP_CONSTS_VH
`define CMEM_JUMP_CONSTS_VH

// compressed word fields
`define QUAD_HI          1
`define QUAD_LO          0
`define FUNC_HI          15
`define FUNC_LO          13
`define BASE_HI          9
`define BASE_LO          7
`define DATA_HI          4
`define DATA_LO          2
`define JREG_SRC_HI      6
`define JREG_SRC_LO      2
`define JREG_DST_HI      11
`define JREG_DST_LO      7

// quadrants
`define QUAD_0           2'h0
`define QUAD_1           2'h1
`define QUAD_2           2'h2

// function codes, quadrant 0
`define F0_WIDE_IMM      3'h0
`define F0_LOAD_DF_Q     3'h1
`define F0_LOAD_W        3'h2
`define F0_LOAD_FW_D     3'h3
`define F0_RESERVED      3'h4
`define F0_STORE_DF_Q    3'h5
`define F0_STORE_W       3'h6
`define F0_STORE_FW_D    3'h7
// function codes, quadrant 1
`define F1_JAL_OR_ADDIW  3'h1
`define F1_JUMP          3'h5
`define F1_BR_ZERO       3'h6
`define F1_BR_NONZERO    3'h7
// function code, quadrant 2 register jumps
`define F2_REG_GROUP     3'h4

// short register fields select registers 8..15
`define SHORT_REG_BASE   2'h1

// base opcodes
`define OP_LOAD          7'h03
`define OP_LOAD_FP       7'h07
`define OP_MISC_MEM      7'h0F
`define OP_STORE         7'h23
`define OP_STORE_FP      7'h27
`define OP_BRANCH        7'h63
`define OP_JALR          7'h67
`define OP_JAL           7'h6F
// base width codes
`define F3_WORD          3'h2
`define F3_DOUBLE        3'h3
`define F3_QUAD_STORE    3'h4
`define F3_QUAD_LOAD     3'h2
`define F3_BEQ           3'h0
`define F3_BNE           3'h1
`define F3_JALR          3'h0
// full breakpoint word
`define BREAKPOINT_WORD  32'h0010_0073
// architectural registers
`define REG_ZERO         5'h00
`define REG_LINK         5'h01

// output formats for the word builder
`define FMT_I            2'h0
`define FMT_S            2'h1
`define FMT_B            2'h2
`define FMT_J            2'h3

// operation classes reported downstream
`define KIND_NONE        3'h0
`define KIND_LOAD        3'h1
`define KIND_STORE       3'h2
`define KIND_JUMP        3'h3
`define KIND_JUMP_REG    3'h4
`define KIND_BR_ZERO     3'h5
`define KIND_BR_NONZERO  3'h6
`define KIND_BREAK       3'h7

`endif

// *** core/base_word_builder.v ***
// assembles a full-width base instruction word from its fields
// assumes: fields come from the expander on the same clock; purely combinational
`timescale 1ns/1ps
`include "cmem_jump_consts.vh"

module base_word_builder (
	// format select and fixed fields
	input  wire [1:0]  fmt,
	input  wire [6:0]  opcode,
	input  wire [2:0]  func_code,
	// register numbers
	input  wire [4:0]  rd,
	input  wire [4:0]  rs1,
	input  wire [4:0]  rs2,
	// byte immediate, bit 0 ignored for branch and jump forms
	input  wire [20:0] imm,
	// assembled word
	output reg  [31:0] word
);

	////////////////////////////////////////////////////////////////////////
	// place immediate bits in the layout of each base format
	always @* begin
		case (fmt)
			`FMT_I: word = {imm[11:0], rs1, func_code, rd, opcode};
			`FMT_S: word = {imm[11:5], rs2, rs1, func_code, imm[4:0], opcode};
			`FMT_B: word = {imm[12], imm[10:5], rs2, rs1, func_code, imm[4:1], imm[11], opcode};
			`FMT_J: word = {imm[20], imm[10:1], imm[11], imm[19:12], rd, opcode};
			default: word = {imm[11:0], rs1, func_code, rd, opcode};
		endcase
	end

endmodule

// *** core/compressed_mem_jump_expander.v ***
// compressed load/store, jump and branch expander with a registered output stage
// assumes: in_word comes from fetch logic on clk; downstream decoder reads the
// registered outputs one cycle after a word is taken
//
// Notes on behaviour
// RULE1: word load, base plus offset times 4
// RULE2: doubleword load, wide bases, offset times 8
// RULE3: quadword load, 128-bit base, offset times 16
// RULE4: single float load, 32-bit base only
// RULE5: double float load, 32/64-bit bases only
// RULE6: word store, base plus offset times 4
// RULE7: doubleword store, wide bases, offset times 8
// RULE8: quadword store, 128-bit base, offset times 16
// RULE9: single float store, 32-bit base only
// RULE10: double float store, 32/64-bit bases only
// RULE11: fixed field positions for load/store words
// RULE12: jump and branch offsets in halfwords
// RULE13: plain jump, signed offset, no link
// RULE14: jump-and-link on 32-bit base writes x1
// RULE15: register jump without link, x0 reserved
// RULE16: register jump-and-link writes pc+2 to x1
// RULE17: link form with x0 source is breakpoint
// RULE18: branch if zero, signed offset, 256 B
// RULE19: branch if nonzero, same target
// RULE20: branch field positions and scattered offset
// RULE21: three-bit field selects register 8..15
// RULE22: reassemble, scale and extend scattered offsets
// RULE23: reserved or unsupported encodings flagged illegal
`timescale 1ns/1ps
`include "cmem_jump_consts.vh"

module compressed_mem_jump_expander #(
	parameter XLEN  = 32, // base width: 32, 64 or 128
	parameter HAS_F = 1,  // single float support
	parameter HAS_D = 1   // double float support
) (
	// clock, reset, enable
	input  wire        clk,
	input  wire        srst,
	input  wire        ce,
	// compressed word from fetch
	input  wire        in_valid,
	input  wire [15:0] in_word,
	// expanded word to the base decoder
	output reg         out_valid_r,
	output reg  [31:0] out_word_r,
	output reg         out_illegal_r,
	output reg         out_unhandled_r,
	output reg         out_link_step2_r,
	output reg  [2:0]  out_kind_r,
	output reg  [31:0] out_offset_r
);

	////////////////////////////////////////////////////////////////////////
	// configuration decode
	localparam IS32  = (XLEN == 32);
	localparam IS64  = (XLEN == 64);
	localparam IS128 = (XLEN == 128);
	localparam FW_OK = IS32 && (HAS_F != 0);
	localparam FD_OK = (IS32 || IS64) && (HAS_D != 0);

	////////////////////////////////////////////////////////////////////////
	// helpers shared by all formats

	// map a three-bit short field onto registers 8 to 15
	function [4:0] short_reg;
		input [2:0] field;
		begin
			short_reg = {`SHORT_REG_BASE, field};
		end
	endfunction

	// zero-extend an unsigned byte offset to the builder width
	function [20:0] zext_off;
		input [8:0] off;
		begin
			zext_off = {12'h000, off};
		end
	endfunction

	// sign-extend a 12-bit byte offset to the builder width
	function [20:0] sext12;
		input [11:0] off;
		begin
			sext12 = {{9{off[11]}}, off};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// field split of the incoming word

	// RULE11: fixed field split
	wire [1:0] quadrant     = in_word[`QUAD_HI:`QUAD_LO];
	wire [2:0] function_code_field = in_word[`FUNC_HI:`FUNC_LO];
	// RULE21: short registers 8..15
	wire [4:0] short_base_register   = short_reg(in_word[`BASE_HI:`BASE_LO]);
	wire [4:0] short_data_register   = short_reg(in_word[`DATA_HI:`DATA_LO]);
	wire [4:0] short_source_register = short_base_register; // branch source shares base slot
	wire [4:0] full_src     = in_word[`JREG_SRC_HI:`JREG_SRC_LO];
	wire [4:0] full_dst     = in_word[`JREG_DST_HI:`JREG_DST_LO];

	////////////////////////////////////////////////////////////////////////
	// scattered offsets reassembled into byte offsets

	// RULE1: word offset times 4
	// RULE22: reassemble scattered bits
	wire [8:0] off_word   = {2'h0, in_word[5], in_word[12:10], in_word[6], 2'h0};
	// RULE2: doubleword offset times 8
	wire [8:0] off_double = {1'h0, in_word[6:5], in_word[12:10], 3'h0};
	// RULE3: quadword offset times 16
	wire [8:0] off_quad   = {in_word[10], in_word[6:5], in_word[12:11], 4'h0};

	// RULE12: halfword units, bit 0 forced low
	// RULE13: plus or minus 2 KiB reach
	wire [11:0] off_jump  = {in_word[12], in_word[8], in_word[10:9], in_word[6], in_word[7],
	                         in_word[2], in_word[11], in_word[5:3], 1'b0};
	// RULE20: branch offset scattered over 12:10 and 6:2
	// RULE18: plus or minus 256 B reach
	wire [8:0] off_branch = {in_word[12], in_word[6:5], in_word[2], in_word[11:10],
	                         in_word[4:3], 1'b0};

	////////////////////////////////////////////////////////////////////////
	// decode into builder fields
	reg        legal_nxt;
	reg        unhandled_nxt;
	reg        link2_nxt;
	reg        brk_nxt;
	reg [2:0]  kind_nxt;
	reg [1:0]  fmt_nxt;
	reg [6:0]  opc_nxt;
	reg [2:0]  f3_nxt;
	reg [4:0]  rd_nxt;
	reg [4:0]  rs1_nxt;
	reg [4:0]  rs2_nxt;
	reg [20:0] imm_nxt;

	// the builder sees one field set; the case below picks it per encoding
	always @* begin
		legal_nxt     = 1'b0;
		unhandled_nxt = 1'b0;
		link2_nxt     = 1'b0;
		brk_nxt       = 1'b0;
		kind_nxt      = `KIND_NONE;
		fmt_nxt       = `FMT_I;
		opc_nxt       = `OP_LOAD;
		f3_nxt        = `F3_WORD;
		rd_nxt        = short_data_register;
		rs1_nxt       = short_base_register;
		rs2_nxt       = short_data_register;
		imm_nxt       = 21'h0_0000;
		case (quadrant)
			`QUAD_0: begin
				case (function_code_field)
					// RULE1: word load
					`F0_LOAD_W: begin
						legal_nxt = 1'b1;
						kind_nxt  = `KIND_LOAD;
						imm_nxt   = zext_off(off_word);
					end
					// RULE4: single float load, else RULE2: doubleword load
					`F0_LOAD_FW_D: begin
						kind_nxt = `KIND_LOAD;
						if (IS32) begin
							legal_nxt = FW_OK;
							opc_nxt   = `OP_LOAD_FP;
							imm_nxt   = zext_off(off_word);
						end else begin
							legal_nxt = 1'b1;
							f3_nxt    = `F3_DOUBLE;
							imm_nxt   = zext_off(off_double);
						end
					end
					// RULE5: double float load, else RULE3: quadword load
					`F0_LOAD_DF_Q: begin
						kind_nxt = `KIND_LOAD;
						if (IS128) begin
							legal_nxt = 1'b1;
							opc_nxt   = `OP_MISC_MEM;
							f3_nxt    = `F3_QUAD_LOAD;
							imm_nxt   = zext_off(off_quad);
						end else begin
							legal_nxt = FD_OK;
							opc_nxt   = `OP_LOAD_FP;
							f3_nxt    = `F3_DOUBLE;
							imm_nxt   = zext_off(off_double);
						end
					end
					// RULE6: word store
					`F0_STORE_W: begin
						legal_nxt = 1'b1;
						kind_nxt  = `KIND_STORE;
						fmt_nxt   = `FMT_S;
						opc_nxt   = `OP_STORE;
						imm_nxt   = zext_off(off_word);
					end
					// RULE9: single float store, else RULE7: doubleword store
					`F0_STORE_FW_D: begin
						kind_nxt = `KIND_STORE;
						fmt_nxt  = `FMT_S;
						if (IS32) begin
							legal_nxt = FW_OK;
							opc_nxt   = `OP_STORE_FP;
							imm_nxt   = zext_off(off_word);
						end else begin
							legal_nxt = 1'b1;
							opc_nxt   = `OP_STORE;
							f3_nxt    = `F3_DOUBLE;
							imm_nxt   = zext_off(off_double);
						end
					end
					// RULE10: double float store, else RULE8: quadword store
					`F0_STORE_DF_Q: begin
						kind_nxt = `KIND_STORE;
						fmt_nxt  = `FMT_S;
						if (IS128) begin
							legal_nxt = 1'b1;
							opc_nxt   = `OP_STORE;
							f3_nxt    = `F3_QUAD_STORE;
							imm_nxt   = zext_off(off_quad);
						end else begin
							legal_nxt = FD_OK;
							opc_nxt   = `OP_STORE_FP;
							f3_nxt    = `F3_DOUBLE;
							imm_nxt   = zext_off(off_double);
						end
					end
					// RULE23: reserved code point
					`F0_RESERVED: legal_nxt = 1'b0;
					// stack-pointer immediate form lives elsewhere
					default: unhandled_nxt = 1'b1;
				endcase
			end
			`QUAD_1: begin
				case (function_code_field)
					// RULE13: plain jump, link to x0
					`F1_JUMP: begin
						legal_nxt = 1'b1;
						kind_nxt  = `KIND_JUMP;
						fmt_nxt   = `FMT_J;
						opc_nxt   = `OP_JAL;
						rd_nxt    = `REG_ZERO;
						imm_nxt   = sext12(off_jump);
					end
					// RULE14: jump-and-link only on the 32-bit base
					`F1_JAL_OR_ADDIW: begin
						if (IS32) begin
							legal_nxt = 1'b1;
							link2_nxt = 1'b1;
							kind_nxt  = `KIND_JUMP;
							fmt_nxt   = `FMT_J;
							opc_nxt   = `OP_JAL;
							rd_nxt    = `REG_LINK;
							imm_nxt   = sext12(off_jump);
						end else begin
							unhandled_nxt = 1'b1; // arithmetic word form on wider bases
						end
					end
					// RULE18: taken when source equals zero
					`F1_BR_ZERO: begin
						legal_nxt = 1'b1;
						kind_nxt  = `KIND_BR_ZERO;
						fmt_nxt   = `FMT_B;
						opc_nxt   = `OP_BRANCH;
						f3_nxt    = `F3_BEQ;
						rs1_nxt   = short_source_register;
						rs2_nxt   = `REG_ZERO;
						imm_nxt   = {{12{off_branch[8]}}, off_branch};
					end
					// RULE19: taken when source is nonzero
					`F1_BR_NONZERO: begin
						legal_nxt = 1'b1;
						kind_nxt  = `KIND_BR_NONZERO;
						fmt_nxt   = `FMT_B;
						opc_nxt   = `OP_BRANCH;
						f3_nxt    = `F3_BNE;
						rs1_nxt   = short_source_register;
						rs2_nxt   = `REG_ZERO;
						imm_nxt   = {{12{off_branch[8]}}, off_branch};
					end
					default: unhandled_nxt = 1'b1;
				endcase
			end
			`QUAD_2: begin
				if (function_code_field == `F2_REG_GROUP && full_src == `REG_ZERO) begin
					if (!in_word[12]) begin
						// RULE15: register jump, x0 reserved
						kind_nxt  = `KIND_JUMP_REG;
						legal_nxt = (full_dst != `REG_ZERO);
						opc_nxt   = `OP_JALR;
						f3_nxt    = `F3_JALR;
						rd_nxt    = `REG_ZERO;
						rs1_nxt   = full_dst;
					end else if (full_dst == `REG_ZERO) begin
						// RULE17: x0 source means breakpoint
						legal_nxt = 1'b1;
						brk_nxt   = 1'b1;
						kind_nxt  = `KIND_BREAK;
					end else begin
						// RULE16: register jump-and-link
						legal_nxt = 1'b1;
						link2_nxt = 1'b1;
						kind_nxt  = `KIND_JUMP_REG;
						opc_nxt   = `OP_JALR;
						f3_nxt    = `F3_JALR;
						rd_nxt    = `REG_LINK;
						rs1_nxt   = full_dst;
					end
				end else begin
					unhandled_nxt = 1'b1; // moves, adds and stack forms
				end
			end
			default: unhandled_nxt = 1'b1; // not a compressed word
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// word assembly
	wire [31:0] built_word;

	base_word_builder u_builder (
		.fmt       (fmt_nxt),
		.opcode    (opc_nxt),
		.func_code (f3_nxt),
		.rd        (rd_nxt),
		.rs1       (rs1_nxt),
		.rs2       (rs2_nxt),
		.imm       (imm_nxt),
		.word      (built_word)
	);

	// RULE23: illegal words carry an all-zero expansion, itself an illegal base word
	wire [31:0] word_nxt    = brk_nxt ? `BREAKPOINT_WORD :
	                          ((legal_nxt && !unhandled_nxt) ? built_word : 32'h0000_0000);
	wire        illegal_nxt = !legal_nxt && !unhandled_nxt;
	// offset reported sign- or zero-extended as the operation needs
	wire [31:0] offset_nxt  = (legal_nxt && !brk_nxt) ? {{11{imm_nxt[20]}}, imm_nxt} : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// output stage; ce low freezes everything, srst wins over ce
	always @(posedge clk) begin
		if (srst) begin
			out_valid_r      <= 1'b0;
			out_word_r       <= 32'h0000_0000;
			out_illegal_r    <= 1'b0;
			out_unhandled_r  <= 1'b0;
			out_link_step2_r <= 1'b0;
			out_kind_r       <= `KIND_NONE;
			out_offset_r     <= 32'h0000_0000;
		end else if (ce) begin
			out_valid_r <= in_valid;
			if (in_valid) begin
				out_word_r       <= word_nxt;
				out_illegal_r    <= illegal_nxt;
				out_unhandled_r  <= unhandled_nxt;
				// RULE14: link value is pc plus 2
				out_link_step2_r <= link2_nxt;
				out_kind_r       <= (illegal_nxt || unhandled_nxt) ? `KIND_NONE : kind_nxt;
				out_offset_r     <= offset_nxt;
			end
		end
	end

endmodule

// *** verification/cmj_checker_sva.sv ***
// checker for the compressed load/store and jump expander
// assumes: bound to the expander, sees only its ports, one clock domain
`timescale 1ns/1ps

module cmj_checker #(
	parameter XLEN  = 32,
	parameter HAS_F = 1,
	parameter HAS_D = 1
) (
	// clock, reset, enable
	input wire        clk,
	input wire        srst,
	input wire        ce,
	// fetch side
	input wire        in_valid,
	input wire [15:0] in_word,
	// decoder side
	input wire        out_valid_r,
	input wire [31:0] out_word_r,
	input wire        out_illegal_r,
	input wire        out_unhandled_r,
	input wire        out_link_step2_r,
	input wire [2:0]  out_kind_r,
	input wire [31:0] out_offset_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// word taken this edge and its quadrant/function selector
	wire        take   = ce & in_valid;
	wire [4:0]  sel    = {in_word[15:13], in_word[1:0]};
	// offsets rebuilt independently from the scattered fields
	wire [31:0] word_off = {25'h0, in_word[5], in_word[12:10], in_word[6], 2'b00};
	wire [31:0] br_off = {{24{in_word[12]}}, in_word[6:5], in_word[2], in_word[11:10], in_word[4:3], 1'b0};
	wire [31:0] j_off  = {{21{in_word[12]}}, in_word[8], in_word[10:9], in_word[6], in_word[7], in_word[2],
		in_word[11], in_word[5:3], 1'b0};

	////////////////////////////////////////////////////////////////////////
	a_word_load: assert property (take && sel == 5'h08 |=> out_kind_r == 3'h1 && out_word_r[19:0] ==
		{2'b01, $past(in_word[9:7]), 3'h2, 2'b01, $past(in_word[4:2]), 7'h03} && out_offset_r == $past(word_off))
		else $error("word load expanded wrongly");
	a_word_store: assert property (take && sel == 5'h18 |=> out_kind_r == 3'h2 && out_word_r[6:0] == 7'h23 &&
		out_word_r[24:20] == {2'b01, $past(in_word[4:2])} && out_word_r[11:7] == $past(word_off[4:0]))
		else $error("word store expanded wrongly");
	a_jump_target: assert property (take && sel == 5'h15 |=> out_kind_r == 3'h3 &&
		out_offset_r == $past(j_off) && out_word_r[11:0] == 12'h06f && !out_link_step2_r)
		else $error("plain jump wrong");
	a_jal_link: assert property (XLEN == 32 && take && sel == 5'h05 |=> out_link_step2_r &&
		out_word_r[11:7] == 5'h01 && out_offset_r == $past(j_off))
		else $error("jump-and-link wrong");
	a_branch_zero: assert property (take && sel == 5'h19 |=> out_kind_r == 3'h5 && out_offset_r == $past(br_off)
		&& out_word_r[19:12] == {2'b01, $past(in_word[9:7]), 3'h0})
		else $error("branch if zero wrong");
	a_branch_nonzero: assert property (take && sel == 5'h1d |=> out_kind_r == 3'h6 &&
		out_offset_r == $past(br_off) && out_word_r[14:12] == 3'h1)
		else $error("branch if nonzero wrong");
	a_rjump_reserved: assert property (take && sel == 5'h12 && in_word[12:2] == 11'h000 |=>
		out_illegal_r && out_word_r == 32'h0000_0000 && out_kind_r == 3'h0)
		else $error("reserved register jump not flagged");
	a_jalr_link: assert property (take && sel == 5'h12 && in_word[12] && in_word[11:7] != 5'h00 &&
		in_word[6:2] == 5'h00 |=> out_link_step2_r && out_word_r == {12'h000, $past(in_word[11:7]), 8'h01, 7'h67})
		else $error("register jump-and-link wrong");
	a_break_word: assert property (take && in_word == 16'h9002 |=> out_kind_r == 3'h7 &&
		out_word_r == 32'h0010_0073)
		else $error("breakpoint word wrong");
	// handshake, freeze and reset behaviour of the output stage
	a_valid_tracks: assert property (ce |=> out_valid_r == $past(in_valid))
		else $error("valid does not follow input");
	a_ce_freeze: assert property (!ce |=> $stable(out_word_r) && $stable(out_valid_r) && $stable(out_kind_r))
		else $error("outputs moved with enable low");
	a_reset_clear: assert property ($fell(srst) |-> !out_valid_r && out_word_r == 32'h0000_0000 &&
		out_kind_r == 3'h0 && !out_illegal_r)
		else $error("reset left outputs set");
endmodule

bind compressed_mem_jump_expander cmj_checker #(.XLEN(XLEN), .HAS_F(HAS_F), .HAS_D(HAS_D)) u_chk (
	.clk(clk), .srst(srst), .ce(ce), .in_valid(in_valid), .in_word(in_word), .out_valid_r(out_valid_r),
	.out_word_r(out_word_r), .out_illegal_r(out_illegal_r), .out_unhandled_r(out_unhandled_r),
	.out_link_step2_r(out_link_step2_r), .out_kind_r(out_kind_r), .out_offset_r(out_offset_r));

// *** verification/decode_sink.sv ***
// far side model: downstream decoder taking each expanded word
// assumes: sits on the registered outputs of the expander, same clock
`timescale 1ns/1ps

module decode_sink (
	// clock, reset, enable
	input wire        clk,
	input wire        srst,
	input wire        ce,
	// expanded word
	input wire        valid,
	input wire [31:0] word,
	// last word taken
	output reg [31:0] last_r
);
	// takes every valid word on an enabled edge; there is no backpressure to model
	always @(posedge clk) begin
		if (srst) begin
			last_r <= 32'h0000_0000;
		end else if (ce && valid) begin
			last_r <= word;
		end
	end
endmodule

// *** verification/tb_compressed_mem_jump_expander.sv ***
// testbench for the compressed load/store and jump expander
// assumes: dut is a 32-bit base with both float kinds, dut_w a 128-bit base
// without float; checker bound in its own file
`timescale 1ns/1ps

module tb_compressed_mem_jump_expander;
	// design connections
	reg         clk;
	reg         srst;
	reg         ce;
	reg         in_valid;
	reg  [15:0] in_word;
	wire        out_valid_r;
	wire [31:0] out_word_r;
	wire        out_illegal_r;
	wire        out_unhandled_r;
	wire        out_link_step2_r;
	wire [2:0]  out_kind_r;
	wire [31:0] out_offset_r;
	wire [31:0] sink_last;
	wire [70:0] seen = {out_valid_r, out_illegal_r, out_unhandled_r, out_link_step2_r, out_kind_r, out_word_r,
		out_offset_r};
	wire [70:0] seen_w;
	integer     fail_count;
	integer     n_tests;
	integer     k;

	compressed_mem_jump_expander #(.XLEN(32), .HAS_F(1), .HAS_D(1)) dut (
		.clk(clk), .srst(srst), .ce(ce), .in_valid(in_valid), .in_word(in_word), .out_valid_r(out_valid_r),
		.out_word_r(out_word_r), .out_illegal_r(out_illegal_r), .out_unhandled_r(out_unhandled_r),
		.out_link_step2_r(out_link_step2_r), .out_kind_r(out_kind_r), .out_offset_r(out_offset_r));
	decode_sink sink (.clk(clk), .srst(srst), .ce(ce), .valid(out_valid_r), .word(out_word_r), .last_r(sink_last));
	// wide base: quad and doubleword forms; the link jump code is another instruction there
	compressed_mem_jump_expander #(.XLEN(128), .HAS_F(0), .HAS_D(0)) dut_w (
		.clk(clk), .srst(srst), .ce(ce), .in_valid(in_valid), .in_word(in_word), .out_valid_r(seen_w[70]),
		.out_word_r(seen_w[63:32]), .out_illegal_r(seen_w[69]), .out_unhandled_r(seen_w[68]),
		.out_link_step2_r(seen_w[67]), .out_kind_r(seen_w[66:64]), .out_offset_r(seen_w[31:0]));

	////////////////////////////////////////////////////////////////////////
	// expected output bundle: valid, {illegal, unhandled, link}, kind, word, offset
	function [70:0] pk(input [2:0] fl, input [2:0] kd, input [31:0] w, input [31:0] o);
		pk = {1'b1, fl, kd, w, o};
	endfunction

	task chk(input string what, input [70:0] got, input [70:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("BAD %s expected %h seen %h", what, exp, got);
			end
		end
	endtask

	// one word in, judged one edge after it is driven
	task go(input string what, input [15:0] w, input [70:0] exp);
		begin
			@(posedge clk);
			in_valid <= 1'b1;
			in_word  <= w;
			@(posedge clk);
			#1;
			chk(what, seen, exp);
		end
	endtask

	// same handshake, judged on the wide-base instance
	task go_w(input string what, input [15:0] w, input [70:0] exp);
		begin
			@(posedge clk);
			in_valid <= 1'b1;
			in_word  <= w;
			@(posedge clk);
			#1;
			chk(what, seen_w, exp);
		end
	endtask

	// scattered quad offsets, doubleword forms and an unhandled code on the wide base
	task t_wide;
		begin
			go_w("quad_load", 16'h2d34, pk(3'h0, 3'h1, 32'h1505_268f, 32'h0000_0150));
			go_w("quad_store", 16'hb0d8, pk(3'h0, 3'h2, 32'h0ae4_c023, 32'h0000_00a0));
			go_w("dbl_load", 16'h743c, pk(3'h0, 3'h1, 32'h0684_3783, 32'h0000_0068));
			go_w("dbl_store", 16'he9f0, pk(3'h0, 3'h2, 32'h0cc5_b823, 32'h0000_00d0));
			go_w("wide_link", 16'h2001, pk(3'h2, 3'h0, 32'h0000_0000, 32'h0000_0000));
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// every load/store code, max and scattered offsets, all short registers
	task t_mem;
		reg [2:0] f;
		reg [2:0] b;
		reg [7:0] o;
		reg       dbl;
		reg [6:0] op;
		begin
			for (k = 0; k < 12; k = k + 1) begin
				f   = 3'((k % 6 < 3) ? k % 6 + 1 : k % 6 + 2);
				b   = 3'(k);
				dbl = (f[1:0] == 2'b01);
				o   = (k < 6) ? (dbl ? 8'hf8 : 8'h7c) : (dbl ? 8'h88 : 8'h44);
				op  = {1'b0, f[2], 2'b00, f[1:0] != 2'b10, 2'b11};
				go("mem", {f, o[5:3], b, dbl ? o[7:6] : {o[2], o[6]}, ~b, 2'b00}, f[2] ?
					pk(3'h0, 3'h2, {4'h0, o[7:5], 2'b01, ~b, 2'b01, b, 2'b01, dbl, o[4:0], op}, {24'h0, o}) :
					pk(3'h0, 3'h1, {4'h0, o, 2'b01, b, 2'b01, dbl, 2'b01, ~b, op}, {24'h0, o}));
			end
		end
	endtask

	// plain jump and jump-and-link at both range ends and a mixed pattern
	task t_jump;
		reg [11:0] o;
		reg        l;
		begin
			for (k = 0; k < 6; k = k + 1) begin
				o = (k % 3 == 0) ? 12'h800 : (k % 3 == 1) ? 12'h7fe : 12'h554;
				l = (k >= 3);
				go("jump", {1'b1 ^ l, 2'b01, o[11], o[4], o[9:8], o[10], o[6], o[7], o[3:1], o[5], 2'b01},
					pk({2'b00, l}, 3'h3, {o[11], o[10:1], o[11], {8{o[11]}}, 4'h0, l, 7'h6f},
					{{20{o[11]}}, o}));
			end
		end
	endtask

	// both branch senses at both range ends
	task t_branch;
		reg [8:0] o;
		reg [2:0] b;
		reg       nz;
		begin
			for (k = 0; k < 6; k = k + 1) begin
				o  = (k % 3 == 0) ? 9'h100 : (k % 3 == 1) ? 9'h0fe : 9'h0aa;
				b  = 3'(k + 3);
				nz = (k >= 3);
				go("branch", {2'b11, nz, o[8], o[4:3], b, o[7:6], o[2:1], o[5], 2'b01},
					pk(3'h0, nz ? 3'h6 : 3'h5, {{3{o[8]}}, o[8:5], 5'h00, 2'b01, b, 2'b00, nz, o[4:1], o[8], 7'h63},
					{{23{o[8]}}, o}));
			end
		end
	endtask

	// register jumps, their x0 forms, and a reserved load/store code
	task t_regjump;
		begin
			go("rjump", 16'h8f82, pk(3'h0, 3'h4, 32'h000f_8067, 32'h0000_0000));
			go("jalr", 16'h9282, pk(3'h1, 3'h4, 32'h0002_80e7, 32'h0000_0000));
			go("rjump_x0", 16'h8002, pk(3'h4, 3'h0, 32'h0000_0000, 32'h0000_0000));
			go("break", 16'h9002, pk(3'h0, 3'h7, 32'h0010_0073, 32'h0000_0000));
			go("resv", 16'h8000, pk(3'h4, 3'h0, 32'h0000_0000, 32'h0000_0000));
		end
	endtask

	// idle hold, enable freeze, and a reset in mid-run
	task t_hold;
		begin
			go("load0", 16'h4000, pk(3'h0, 3'h1, 32'h0004_2403, 32'h0000_0000));
			@(posedge clk);
			in_valid <= 1'b0;
			in_word  <= 16'h9002;
			@(posedge clk);
			#1;
			chk("idle", seen, {1'b0, 3'h0, 3'h1, 32'h0004_2403, 32'h0000_0000});
			chk("sink", {39'h0, sink_last}, {39'h0, 32'h0004_2403});
			@(posedge clk);
			ce       <= 1'b0;
			in_valid <= 1'b1;
			repeat (2) @(posedge clk);
			#1;
			chk("frozen", seen, {1'b0, 3'h0, 3'h1, 32'h0004_2403, 32'h0000_0000});
			@(posedge clk);
			ce <= 1'b1;
			@(posedge clk);
			#1;
			chk("thaw", seen, pk(3'h0, 3'h7, 32'h0010_0073, 32'h0000_0000));
			@(posedge clk);
			srst <= 1'b1;
			@(posedge clk);
			#1;
			chk("reset", seen, {71{1'b0}});
			@(posedge clk);
			srst     <= 1'b0;
			in_valid <= 1'b0;
			// first edge after release: still clear, then a word goes straight through
			@(posedge clk);
			#1;
			chk("released", seen, {71{1'b0}});
			go("post", 16'h4000, pk(3'h0, 3'h1, 32'h0004_2403, 32'h0000_0000));
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		begin
			if (fail_count == 0 && n_tests > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask

	// 10 ns clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// run is about 100 cycles; the watchdog allows twenty times that
	initial begin
		repeat (2000) @(posedge clk);
		fail_count = fail_count + 1;
		tally_and_finish;
	end

	initial begin
		fail_count = 0;
		n_tests    = 0;
		srst       = 1'b1;
		ce         = 1'b1;
		in_valid   = 1'b0;
		in_word    = 16'h0000;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_mem;
		t_jump;
		t_branch;
		t_regjump;
		t_wide;
		t_hold;
		repeat (2) @(posedge clk);
		tally_and_finish;
	end
endmodule
